// >>> eec_pkg.sv
// Purpose: Shared constants for the two-wire EEPROM client write front end
// Assumes: mclk at 125 MHz; serial bus pins sampled asynchronously
// Notes: Type identifier value is arbitrary and set by parameter at the top
package eec_pkg;
  localparam int EEC_CLK_MHZ = 125;
  localparam int EEC_PAGES = 128;
  localparam int EEC_PAGE_BYTES = 32;
  localparam int EEC_MEM_BYTES = EEC_PAGES * EEC_PAGE_BYTES;
  localparam int EEC_ADDR_W = 12;
  localparam int EEC_COL_W = 5;
  localparam int EEC_DATA_W = 8;
  localparam int EEC_BITS_PER_BYTE = 8;
  localparam int EEC_RECOVERY_PULSES = 9;
  // Programming time in microseconds and its count of mclk cycles
  localparam int EEC_PROG_TIME_US = 5000;
  localparam int EEC_PROG_CYCLES = EEC_PROG_TIME_US * EEC_CLK_MHZ;
  localparam logic [3:0] EEC_TYPE_ID_DEFAULT = 4'h6;
  localparam int EEC_TYPE_MSB = 7;
  localparam int EEC_TYPE_LSB = 4;
  localparam int EEC_SEL_MSB = 3;
  localparam int EEC_SEL_LSB = 1;
  localparam int EEC_RW_BIT = 0;
  localparam int EEC_HI_ADDR_W = 4;

  typedef enum logic [2:0] {
    EEC_ST_IDLE = 3'b000,
    EEC_ST_DEVADR = 3'b001,
    EEC_ST_ADDR_HI = 3'b010,
    EEC_ST_ADDR_LO = 3'b011,
    EEC_ST_DATA = 3'b100,
    EEC_ST_IGNORE = 3'b101
  } eec_state_t;
endpackage : eec_pkg

// >>> eec_sync.sv
// Purpose: Two-stage synchroniser for the serial bus pins
// Assumes: inputs asynchronous to mclk
// Notes: The first stage is read only by the second stage
module eec_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // Reset to ones: an idle bus floats high
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : eec_sync

// >>> eec_prog_timer.sv
// Purpose: Self-timed programming cycle timer
// Assumes: start is a one-cycle pulse
// Notes: busy rises the cycle after start and falls after CYCLES cycles
module eec_prog_timer #(
  parameter int CYCLES = 625000
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  output logic busy
);
  logic [$clog2(CYCLES+1)-1:0] count;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      busy <= 1'b0;
    end else if (start && !busy) begin
      count <= ($clog2(CYCLES+1))'(CYCLES - 1);
      busy <= 1'b1;
    end else if (busy) begin
      if (count == '0) begin
        busy <= 1'b0;
      end else begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : eec_prog_timer

// >>> eec_client.sv
// Purpose: Two-wire serial EEPROM client front end, address match and page write
// Assumes: serial clock is far slower than mclk; bus host is the only clock source
// Notes: Read transfers and write protection are outside this block

// Notes on behaviour
// - Standby after reset, after a Stop without programming, and after programming.
// - Clock pulses after an aborted transfer release data; the frame state holds until a Start or Stop.
// - Data line is released within nine dummy clock pulses.
// - Array is 128 pages of 32 bytes, 4096 locations.
// - Upper four address-byte bits must equal the type identifier.
// - Address bits 3 to 1 compare against the three select pins.
// - Address bit 0 high means read, low means write.
// - Matching address byte is acknowledged; mismatch is not.
// - First word byte low nibble gives bits 11 to 8; acknowledged.
// - Second word byte gives bits 7 to 0; acknowledged.
// - Stop after the last acknowledged data byte starts programming.
// - During programming inputs are ignored and nothing is driven.
// - One write cycle programs up to 32 bytes within one page.
// - Every data byte received is acknowledged, with no limit of 32 per page.
// - Only the low five address bits increment, wrapping inside the page.
// - No acknowledge during programming; immediate acknowledge after it.
// - Bits sampled on rising clock, driven after falling edge, MSB first.
// - Falling data with clock high is Start, waking the device.
// - Rising data with clock high is Stop, ending the transfer.
// - Acknowledge holds data low through the whole ninth clock high phase.
module eec_client
  import eec_pkg::*;
#(
  parameter logic [3:0] TYPE_ID = EEC_TYPE_ID_DEFAULT, // Arbitrary value
  parameter int PROG_CYCLES = EEC_PROG_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic hw_select_pin_2,
  input wire logic hw_select_pin_1,
  input wire logic hw_select_pin_0,
  output logic standby,
  output logic prog_busy,
  output logic read_request,
  output logic [EEC_ADDR_W-1:0] word_addr,
  output logic wr_en,
  output logic [EEC_ADDR_W-1:0] wr_addr,
  output logic [EEC_DATA_W-1:0] wr_data
);
  logic [1:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic [2:0] sel_pins;
  logic [2:0] sel_pins_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  eec_state_t state;
  logic [3:0] bit_cnt;
  logic [EEC_DATA_W-1:0] shreg;
  logic ack_phase;
  logic ack_drive;
  logic pending;
  logic prog_start;
  logic timer_busy;
  logic [EEC_ADDR_W-1:0] addr;
  logic [EEC_ADDR_W-1:0] next_addr;
  logic [EEC_DATA_W-1:0] next_byte;
  // Decoded bus events
  logic bus_live;
  logic in_frame;
  logic bit_take;
  logic byte_end;
  logic ack_start;
  logic ack_end;
  logic dev_hit;
  logic data_end;
  eec_state_t next_state;

  function automatic logic addr_match(input logic [EEC_DATA_W-1:0] b, input logic [2:0] sel,
                                      input logic [3:0] id);
    addr_match = (b[EEC_TYPE_MSB:EEC_TYPE_LSB] == id) &&
                 (b[EEC_SEL_MSB:EEC_SEL_LSB] == sel);
  endfunction : addr_match

  eec_sync #(.WIDTH(2)) u_bus_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_sync)
  );

  eec_sync #(.WIDTH(3)) u_sel_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async_in({hw_select_pin_2, hw_select_pin_1, hw_select_pin_0}),
    .sync_out(sel_pins_s)
  );

  // Program cycle length comes from PROG_CYCLES; the bus is deaf while it runs
  eec_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(prog_start),
    .busy(timer_busy)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];
  assign sel_pins = sel_pins_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  // No condition is seen while a program cycle runs
  assign start_det = scl_s && scl_d && sda_d && !sda_s && !timer_busy;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s && !timer_busy;
  assign next_byte = {shreg[EEC_DATA_W-2:0], sda_s};
  // Low five bits wrap within the page, upper bits hold the row
  assign next_addr = {addr[EEC_ADDR_W-1:EEC_COL_W], addr[EEC_COL_W-1:0] + 1'b1};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Conditions outrank bit traffic, and a running program cycle outranks both
  assign bus_live = !timer_busy && !start_det && !stop_det;
  // An ignored frame still finishes the acknowledge clock it has begun
  assign in_frame = (state != EEC_ST_IDLE) && !(state == EEC_ST_IGNORE && !ack_phase);
  assign bit_take = bus_live && in_frame && scl_rise && !ack_phase;
  assign byte_end = bit_take && (bit_cnt == 4'(EEC_BITS_PER_BYTE - 1));
  assign ack_start = bus_live && in_frame && scl_fall && ack_phase && (bit_cnt == 4'(EEC_BITS_PER_BYTE));
  assign ack_end = bus_live && in_frame && scl_fall && ack_phase && (bit_cnt == 4'(EEC_BITS_PER_BYTE + 1));
  assign dev_hit = addr_match(next_byte, sel_pins, TYPE_ID);
  assign data_end = byte_end && (state == EEC_ST_DATA);

  // Protocol state
  always_comb begin
    next_state = state;
    if (timer_busy) begin
      next_state = EEC_ST_IDLE;
    end else if (start_det) begin
      next_state = EEC_ST_DEVADR;
    end else if (stop_det) begin
      next_state = EEC_ST_IDLE;
    end else if (byte_end) begin
      unique case (state)
        EEC_ST_DEVADR: begin
          if (dev_hit && !next_byte[EEC_RW_BIT]) begin
            next_state = EEC_ST_ADDR_HI;
          end else begin
            // Reads are only acknowledged; a refused address waits for the next Start
            next_state = EEC_ST_IGNORE;
          end
        end
        EEC_ST_ADDR_HI: begin
          next_state = EEC_ST_ADDR_LO;
        end
        EEC_ST_ADDR_LO: begin
          next_state = EEC_ST_DATA;
        end
        EEC_ST_DATA: begin
          next_state = EEC_ST_DATA;
        end
        default: begin
          next_state = EEC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= EEC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit counter and acknowledge phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt <= '0;
      ack_phase <= 1'b0;
    end else if (!bus_live) begin
      bit_cnt <= '0;
      ack_phase <= 1'b0;
    end else if (bit_take) begin
      bit_cnt <= bit_cnt + 1'b1;
      ack_phase <= byte_end;
    end else if (ack_start) begin
      // Pulling low waits for the falling edge of the eighth bit, else it would fake a Start
      bit_cnt <= 4'(EEC_BITS_PER_BYTE + 1);
    end else if (ack_end) begin
      // Falling edge ending the ninth clock releases the line
      bit_cnt <= '0;
      ack_phase <= 1'b0;
    end
  end

  // Received bits, most significant first
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shreg <= '0;
    end else if (bit_take) begin
      shreg <= next_byte;
    end
  end

  // Acknowledge request: address hit, both word bytes and every data byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_drive <= 1'b0;
    end else if (!bus_live || ack_end) begin
      ack_drive <= 1'b0;
    end else if (byte_end) begin
      ack_drive <= (state != EEC_ST_DEVADR) || dev_hit;
    end
  end

  // A repeated Start or a Stop drops the flag; only a Stop turns it into a program cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pending <= 1'b0;
    end else if (!bus_live) begin
      pending <= 1'b0;
    end else if (data_end) begin
      pending <= 1'b1;
    end
  end

  // Word address; only the column part advances after a data byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr <= '0;
    end else if (byte_end && state == EEC_ST_ADDR_HI) begin
      addr[EEC_ADDR_W-1:EEC_DATA_W] <= next_byte[EEC_HI_ADDR_W-1:0];
    end else if (byte_end && state == EEC_ST_ADDR_LO) begin
      addr[EEC_DATA_W-1:0] <= next_byte;
    end else if (data_end) begin
      addr <= next_addr;
    end
  end

  // Page buffer load strobe and read notice, one cycle each
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      read_request <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      read_request <= byte_end && state == EEC_ST_DEVADR && dev_hit && next_byte[EEC_RW_BIT];
      wr_en <= data_end;
      if (data_end) begin
        wr_addr <= addr;
        wr_data <= next_byte;
      end
    end
  end

  assign prog_start = stop_det && pending && !timer_busy;

  // Data line driver; a released line reads high so recovery pulses finish it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      // Drive only while acknowledging; any aborted ack ends at the next falling edge
      sda_oe <= ack_drive && ack_phase && bit_cnt == 4'(EEC_BITS_PER_BYTE + 1) && !timer_busy;
    end
  end

  // Current location and status outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      standby <= 1'b1;
      prog_busy <= 1'b0;
      word_addr <= '0;
    end else begin
      prog_busy <= timer_busy || prog_start;
      word_addr <= addr;
      if (start_det) begin
        standby <= 1'b0;
      end else if (prog_start) begin
        standby <= 1'b0;
      end else if (stop_det || (prog_busy && !timer_busy)) begin
        standby <= 1'b1;
      end
    end
  end
endmodule : eec_client

// >>> eec_client_properties.sv
// Purpose: Port-level checks of the EEPROM client write front end
// Assumes: one mclk domain, rst_b active low
// Notes: Busy length is allowed one cycle of slack either way
module eec_client_properties
  import eec_pkg::*;
  #(parameter int PROG_CYCLES = EEC_PROG_CYCLES) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic standby,
  input wire logic prog_busy,
  input wire logic read_request,
  input wire logic wr_en,
  input wire logic [EEC_ADDR_W-1:0] wr_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  int busy_cnt;
  int wr_gap;
  logic [EEC_ADDR_W-1:0] wr_last;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) busy_cnt <= 0;
    else busy_cnt <= prog_busy ? busy_cnt + 1 : 0;
  end
  // A gap this short means both bytes belong to one write
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_gap <= 1000;
      wr_last <= '0;
    end else if (wr_en) begin
      wr_gap <= 0;
      wr_last <= wr_addr;
    end else if (wr_gap < 1000) wr_gap <= wr_gap + 1;
  end
  sequence s_ack_soon;
    ##[0:8] sda_oe;
  endsequence
  property p_open_drain; sda_oe |-> !sda_out; endproperty
  property p_ack_holds; $rose(sda_oe) |-> sda_oe [*8]; endproperty
  property p_busy_quiet; prog_busy |-> !sda_oe; endproperty
  property p_busy_awake; prog_busy |-> !standby; endproperty
  property p_done_standby; $fell(prog_busy) |-> ##[0:2] standby; endproperty
  property p_busy_len; $fell(prog_busy) |-> busy_cnt >= PROG_CYCLES - 1 && busy_cnt <= PROG_CYCLES + 1; endproperty
  property p_data_ack; wr_en |-> s_ack_soon; endproperty
  property p_read_ack; read_request |-> s_ack_soon; endproperty
  property p_page_step; wr_en && wr_gap < 120 |-> wr_addr == {wr_last[11:5], wr_last[4:0] + 5'h01}; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  a_ack_holds: assert property (p_ack_holds) else $error("ack too short");
  a_busy_quiet: assert property (p_busy_quiet) else $error("ack while programming");
  a_busy_awake: assert property (p_busy_awake) else $error("standby while programming");
  a_done_standby: assert property (p_done_standby) else $error("no standby after programming");
  a_busy_len: assert property (p_busy_len) else $error("programming length wrong");
  a_data_ack: assert property (p_data_ack) else $error("data byte not acked");
  a_read_ack: assert property (p_read_ack) else $error("read address not acked");
  a_page_step: assert property (p_page_step) else $error("address step wrong");
endmodule : eec_client_properties

// >>> eec_host_model.sv
// Purpose: Two-wire bus host model, 80 ns serial clock
// Assumes: tasks entered just after a falling mclk edge
// Notes: Clock stands still between frames; data floats high via pull-up
module eec_host_model (
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    sda_low = 1'b0;
    #16 scl = 1'b1;
    #24 sda_low = 1'b1;
    #24 scl = 1'b0;
    #16;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    #16 scl = 1'b1;
    #24 sda_low = 1'b0;
    #40;
  endtask : stop
  // With hold set the host stalls in the ack high phase
  task automatic xfer(input logic [7:0] b, output logic ack, input logic hold);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      #16 scl = 1'b1;
      #40 scl = 1'b0;
      #24;
    end
    sda_low = 1'b0;
    #16 scl = 1'b1;
    if (hold) return;
    #24 ack = !sda;
    #16 scl = 1'b0;
    #24;
  endtask : xfer
  task automatic recover(output int n);
    n = 0;
    while (!sda && n < 12) begin
      #40 scl = 1'b0;
      #40 scl = 1'b1;
      n++;
    end
  endtask : recover
endmodule : eec_host_model

// >>> eec_client_test.sv
// Purpose: Self-checking bench of the EEPROM client write front end
// Assumes: short programming time for simulation
// Notes: Expected addresses follow page-local wrapping
module eec_client_test
  import eec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PROG = 300;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] sel = 3'h5;
  logic scl, sda_low, sda, sda_oe, sda_out, standby, prog_busy, read_request, wr_en, ack;
  logic [EEC_ADDR_W-1:0] word_addr, wr_addr;
  logic [EEC_DATA_W-1:0] wr_data;
  logic [EEC_ADDR_W-1:0] wa[$];
  logic [EEC_DATA_W-1:0] wd[$];
  int failures = 0, n_checks = 0, cyc = 0, n_rd = 0, n;
  always #4 mclk = ~mclk;
  assign sda = !(sda_low || (sda_oe && !sda_out));
  eec_host_model i_host (.sda(sda), .scl(scl), .sda_low(sda_low));
  eec_client #(.PROG_CYCLES(PROG)) i_dut (.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .hw_select_pin_2(sel[2]), .hw_select_pin_1(sel[1]),
    .hw_select_pin_0(sel[0]), .standby(standby), .prog_busy(prog_busy), .read_request(read_request),
    .word_addr(word_addr), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  always @(negedge mclk) begin
    if (wr_en) begin
      wa.push_back(wr_addr);
      wd.push_back(wr_data);
    end
    if (read_request) n_rd++;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  function automatic logic [7:0] dev(input logic rw);
    return {EEC_TYPE_ID_DEFAULT, sel, rw};
  endfunction : dev
  task automatic send(input logic [7:0] b, input logic exp);
    i_host.xfer(b, ack, 1'b0);
    check(ack, exp);
  endtask : send
  initial begin
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    i_host.start();
    send({~EEC_TYPE_ID_DEFAULT, sel, 1'b0}, 1'b0);
    send(8'h00, 1'b0);
    i_host.stop();
    check(standby, 1'b1);
    i_host.start();
    send({EEC_TYPE_ID_DEFAULT, ~sel, 1'b0}, 1'b0);
    i_host.stop();
    i_host.start();
    send(dev(1'b0), 1'b1);
    send(8'hF3, 1'b1);
    send(8'h1E, 1'b1);
    for (int i = 0; i < 3; i++) send(8'(8'hA5 + i), 1'b1);
    i_host.stop();
    repeat (2) @(negedge mclk);
    check(prog_busy, 1'b1);
    check(standby, 1'b0);
    check(word_addr, {4'h3, 3'h0, 5'h01});
    for (int i = 0; i < 3; i++) begin
      check(wa[i], {4'h3, 3'h0, 5'(5'h1E + i)});
      check(wd[i], 8'(8'hA5 + i));
    end
    n = 0;
    ack = 1'b0;
    while (!ack && n < 10) begin
      i_host.start();
      i_host.xfer(dev(1'b0), ack, 1'b0);
      if (!ack) i_host.stop();
      n++;
    end
    check(n > 1, 1'b1);
    i_host.stop();
    repeat (2) @(negedge mclk);
    check(standby, 1'b1);
    i_host.start();
    send(dev(1'b0), 1'b1);
    send(8'h00, 1'b1);
    send(8'h40, 1'b1);
    send(8'h5A, 1'b1);
    i_host.start();
    send(dev(1'b1), 1'b1);
    check(16'(n_rd), 16'h0001);
    check(16'(wa.size()), 16'h0004);
    i_host.stop();
    repeat (2) @(negedge mclk);
    check(prog_busy, 1'b0);
    check(standby, 1'b1);
    i_host.start();
    i_host.xfer(dev(1'b0), ack, 1'b1);
    check(sda, 1'b0);
    i_host.recover(n);
    check(sda, 1'b1);
    check(n <= EEC_RECOVERY_PULSES, 1'b1);
    i_host.start();
    send(dev(1'b0), 1'b1);
    i_host.stop();
    sel = 3'h0;
    i_host.start();
    send(dev(1'b0), 1'b1);
    i_host.stop();
    wrap_up();
  end
endmodule : eec_client_test
bind eec_client eec_client_properties #(.PROG_CYCLES(PROG_CYCLES)) i_props (.mclk(mclk), .rst_b(rst_b),
  .sda_out(sda_out), .sda_oe(sda_oe), .standby(standby), .prog_busy(prog_busy),
  .read_request(read_request), .wr_en(wr_en), .wr_addr(wr_addr));
